/* File: rtl/tsq_cmd_top.sv */
// Command interpreter: sensor readouts, status flags and port setup
// Behaviour
// - Zeroed readout replies name then 32 values minus stored baseline.
// - Uncorrected readout replies name then 32 raw values.
// - Each field value is signed 16-bit, clamped to magnitude 16000.
// - Status query takes no arguments, replies name and one flags byte.
// - Flags: bit0 right, bit1 left marker, bits3:2 track, bit4 fault.
// - Tape polarity code 0 is north on top, 1 south on top.
// - Changing tape polarity sets marker polarity to its opposite.
// - Tape polarity query replies name and current code.
// - Link protocol 0 serial (default), 1 lightweight CAN, 2 CANopen.
// - Serial bitrate codes 0..4 map 9600..115200; default 115200.
// - Serial inversion 0 leaves lines plain (default), 1 inverts both.
// - Serial setup query replies name, bitrate code and inversion.
// - One set of CAN parameters serves both CAN protocol modes.
// - Node id 1..127 default 1; send period 16-bit ms default 20.
// - Baseline capture stores the ambient field of every sensor.
`timescale 1ns/1ps
module tsq_cmd_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  output logic      [4:0]  sensor_idx_o,
  input  wire logic [15:0] sensor_val_i,
  input  wire logic        right_marker_i,
  input  wire logic        left_marker_i,
  input  wire logic [1:0]  track_detect_i,
  input  wire logic        sensor_fault_i,
  output logic             tape_pol_o,
  output logic             marker_pol_o,
  output logic      [1:0]  link_mode_o,
  output logic      [2:0]  baud_code_o,
  output logic             serial_inv_o,
  output logic      [7:0]  can_node_o,
  output logic      [1:0]  can_rate_o,
  output logic      [15:0] can_period_o,
  output logic             can_term_o
);
  typedef enum logic [8:0] {
    S_IDLE  = 9'b000000001,
    S_EXEC  = 9'b000000010,
    S_NAME  = 9'b000000100,
    S_COMMA = 9'b000001000,
    S_NUM   = 9'b000010000,
    S_WAIT  = 9'b000100000,
    S_ACK   = 9'b001000000,
    S_END   = 9'b010000000,
    S_ZERO  = 9'b100000000
  } tsq_state_t;

  tsq_state_t         state;
  logic               line_stb;
  logic               is_get;
  logic [31:0]        name;
  logic [2:0]         argc;
  logic [3:0][15:0]   args;
  logic               bad;
  logic [15:0]        base [32];
  logic [5:0]         item;
  logic [5:0]         n_items;
  logic [2:0]         name_idx;
  logic [7:0]         ack_chr;
  logic               enable;
  logic               last_err;
  logic [7:0]         line_cnt;
  logic [5:0]         get_n;
  logic               set_ok;
  logic               slot_free;
  logic               load;
  logic [7:0]         load_byte;
  logic               fmt_valid;
  logic [7:0]         fmt_data;
  logic               fmt_done;
  logic signed [17:0] raw_v;
  logic signed [17:0] sel_v;
  logic signed [17:0] sens_v;
  logic signed [17:0] item_v;
  logic [7:0]         flags;
  logic               wb_req;

  assign rx_ready_o   = (state == S_IDLE) && enable && !line_stb;
  assign sensor_idx_o = item[4:0];
  assign slot_free    = !tx_valid_o || tx_ready_i;
  assign wb_req       = wb_cyc_i && wb_stb_i && !wb_ack_o;

  tsq_line_parser u_parser (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .byte_stb_i (rx_valid_i && rx_ready_o),
    .byte_i     (rx_data_i),
    .line_stb_o (line_stb),
    .is_get_o   (is_get),
    .name_o     (name),
    .argc_o     (argc),
    .args_o     (args),
    .bad_o      (bad)
  );

  tsq_dec_fmt u_fmt (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (state == S_NUM),
    .value_i     (item_v),
    .out_valid_o (fmt_valid),
    .out_data_o  (fmt_data),
    .out_ready_i (slot_free && state == S_WAIT),
    .done_o      (fmt_done)
  );

  // Reply value of the current item
  always_comb begin
    flags = {3'h0, sensor_fault_i, track_detect_i,
             left_marker_i, right_marker_i};
    raw_v = {{2{sensor_val_i[15]}}, sensor_val_i};
    sel_v = (name == tsq_pkg::CMD_ZEROED)
          ? raw_v - {{2{base[item[4:0]][15]}}, base[item[4:0]]}
          : raw_v;
    if (sel_v > tsq_pkg::FIELD_LIMIT) sens_v = tsq_pkg::FIELD_LIMIT;
    else if (sel_v < -tsq_pkg::FIELD_LIMIT) sens_v = -tsq_pkg::FIELD_LIMIT;
    else sens_v = sel_v;
    item_v = 18'sh0;
    case (name)
      tsq_pkg::CMD_ZEROED, tsq_pkg::CMD_UNCORR: item_v = sens_v;
      tsq_pkg::CMD_STATUS: item_v = {10'h0, flags};
      tsq_pkg::CMD_TAPE:   item_v = {17'h0, tape_pol_o};
      tsq_pkg::CMD_LINK:   item_v = {16'h0, link_mode_o};
      tsq_pkg::CMD_SERIAL: item_v = (item == 6'h0)
                                  ? {15'h0, baud_code_o}
                                  : {17'h0, serial_inv_o};
      tsq_pkg::CMD_CAN: case (item[1:0])
        2'h0:    item_v = {10'h0, can_node_o};
        2'h1:    item_v = {16'h0, can_rate_o};
        2'h2:    item_v = {2'h0, can_period_o};
        default: item_v = {17'h0, can_term_o};
      endcase
      default: item_v = 18'sh0;
    endcase
  end

  // Command validation
  always_comb begin
    get_n  = 6'h0;
    set_ok = 1'b0;
    if (!bad && is_get && argc == 3'h0) begin
      case (name)
        tsq_pkg::CMD_ZEROED, tsq_pkg::CMD_UNCORR: get_n = tsq_pkg::N_SENSORS;
        tsq_pkg::CMD_STATUS, tsq_pkg::CMD_TAPE,
        tsq_pkg::CMD_LINK:   get_n = tsq_pkg::N_ONE;
        tsq_pkg::CMD_SERIAL: get_n = tsq_pkg::N_SERIAL;
        tsq_pkg::CMD_CAN:    get_n = tsq_pkg::N_CAN;
        default:             get_n = 6'h0;
      endcase
    end else if (!bad && !is_get) begin
      case (name)
        tsq_pkg::CMD_TAPE: set_ok = argc == 3'h1 &&
                                    args[0] <= tsq_pkg::LIM_BIT;
        tsq_pkg::CMD_LINK: set_ok = argc == 3'h1 &&
                                    args[0] <= tsq_pkg::LIM_LINK;
        tsq_pkg::CMD_SERIAL: set_ok = argc == 3'h2 &&
                                      args[0] <= tsq_pkg::LIM_BAUD &&
                                      args[1] <= tsq_pkg::LIM_BIT;
        tsq_pkg::CMD_CAN: set_ok = argc == 3'h4 &&
                                   args[0] >= tsq_pkg::LIM_BIT &&
                                   args[0] <= tsq_pkg::LIM_NODE &&
                                   args[1] <= tsq_pkg::LIM_CRATE &&
                                   args[3] <= tsq_pkg::LIM_BIT;
        tsq_pkg::CMD_ZERO: set_ok = argc == 3'h0;
        default:           set_ok = 1'b0;
      endcase
    end
  end

  // Byte offered to the transmit holding register
  always_comb begin
    load      = 1'b0;
    load_byte = tsq_pkg::CHR_CR;
    case (state)
      S_NAME: begin
        load = slot_free;
        case (name_idx)
          3'h0:    load_byte = tsq_pkg::CHR_GET;
          3'h1:    load_byte = name[31:24];
          3'h2:    load_byte = name[23:16];
          3'h3:    load_byte = name[15:8];
          default: load_byte = name[7:0];
        endcase
      end
      S_COMMA: begin
        load      = slot_free;
        load_byte = tsq_pkg::CHR_COMMA;
      end
      S_WAIT: begin
        load      = slot_free && fmt_valid;
        load_byte = fmt_data;
      end
      S_ACK: begin
        load      = slot_free;
        load_byte = ack_chr;
      end
      S_END: load = slot_free;
      default: load = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
    end else if (load) begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= load_byte;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= S_IDLE;
      item     <= 6'h0;
      n_items  <= 6'h0;
      name_idx <= 3'h0;
      ack_chr  <= tsq_pkg::CHR_OK;
    end else begin
      case (state)
        S_IDLE: if (line_stb) state <= S_EXEC;
        S_EXEC: begin
          item     <= 6'h0;
          name_idx <= 3'h0;
          n_items  <= get_n;
          if (get_n != 6'h0) state <= S_NAME;
          else if (set_ok && name == tsq_pkg::CMD_ZERO) state <= S_ZERO;
          else begin
            ack_chr <= set_ok ? tsq_pkg::CHR_OK : tsq_pkg::CHR_MINUS;
            state   <= S_ACK;
          end
        end
        S_NAME: if (slot_free) begin
          name_idx <= name_idx + 3'h1;
          if (name_idx == 3'h4) state <= S_COMMA;
        end
        S_COMMA: if (slot_free) state <= S_NUM;
        S_NUM:   state <= S_WAIT;
        S_WAIT: if (fmt_done) begin
          if (item == n_items - 6'h1) state <= S_END;
          else begin
            item  <= item + 6'h1;
            state <= S_COMMA;
          end
        end
        S_ZERO: begin
          item <= item + 6'h1;
          if (item[4:0] == tsq_pkg::SENS_LAST) begin
            ack_chr <= tsq_pkg::CHR_OK;
            state   <= S_ACK;
          end
        end
        S_ACK: if (slot_free) state <= S_END;
        S_END: if (slot_free) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Baseline store; the host is expected to clear the track first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) base[i] <= 16'h0000;
    end else if (state == S_ZERO) begin
      base[item[4:0]] <= sensor_val_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tape_pol_o   <= tsq_pkg::DEF_TAPE_POL;
      marker_pol_o <= !tsq_pkg::DEF_TAPE_POL;
      link_mode_o  <= tsq_pkg::DEF_LINK;
      baud_code_o  <= tsq_pkg::DEF_BAUD;
      serial_inv_o <= tsq_pkg::DEF_INV;
      can_node_o   <= tsq_pkg::DEF_NODE;
      can_rate_o   <= tsq_pkg::DEF_CRATE;
      can_period_o <= tsq_pkg::DEF_PERIOD;
      can_term_o   <= tsq_pkg::DEF_TERM;
    end else if (state == S_EXEC && set_ok) begin
      case (name)
        tsq_pkg::CMD_TAPE: begin
          tape_pol_o   <= args[0][0];
          marker_pol_o <= !args[0][0];
        end
        tsq_pkg::CMD_LINK: link_mode_o <= args[0][1:0];
        tsq_pkg::CMD_SERIAL: begin
          baud_code_o  <= args[0][2:0];
          serial_inv_o <= args[1][0];
        end
        tsq_pkg::CMD_CAN: begin
          can_node_o   <= args[0][7:0];
          can_rate_o   <= args[1][1:0];
          can_period_o <= args[2];
          can_term_o   <= args[3][0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_err <= 1'b0;
      line_cnt <= 8'h00;
    end else if (state == S_EXEC) begin
      last_err <= (get_n == 6'h0) && !set_ok;
      line_cnt <= line_cnt + 8'h01;
    end
  end

  // Wishbone slave: answers every access one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      enable   <= tsq_pkg::DEF_ENABLE;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == tsq_pkg::ADR_CTRL && wb_sel_i[0])
          enable <= wb_dat_i[0];
      end else if (wb_req) begin
        if (wb_adr_i == tsq_pkg::ADR_CTRL) wb_dat_o <= {31'h0, enable};
        else if (wb_adr_i == tsq_pkg::ADR_STAT)
          wb_dat_o <= {16'h0, line_cnt, 4'h0, marker_pol_o, tape_pol_o,
                       last_err, state != S_IDLE};
        else if (wb_adr_i == tsq_pkg::ADR_CFG)
          wb_dat_o <= {can_period_o, can_node_o[6:0], can_term_o, can_rate_o,
                       link_mode_o, serial_inv_o, baud_code_o};
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_marker_opp;
    $changed(tape_pol_o) |-> marker_pol_o != tape_pol_o;
  endproperty
  a_marker_opp: assert property (p_marker_opp)
    else $error("marker polarity not opposite of tape");

  property p_clamp;
    state == S_NUM && name == tsq_pkg::CMD_ZEROED |->
      item_v <= tsq_pkg::FIELD_LIMIT && item_v >= -tsq_pkg::FIELD_LIMIT;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("field value beyond limit");

  property p_flags;
    state == S_NUM && name == tsq_pkg::CMD_STATUS |->
      item_v[4:0] == {sensor_fault_i, track_detect_i,
                      left_marker_i, right_marker_i} && item_v[17:5] == 0;
  endproperty
  a_flags: assert property (p_flags)
    else $error("status flags misplaced");

  property p_zeroed;
    state == S_NUM && name == tsq_pkg::CMD_ZEROED &&
      $signed(sensor_val_i) == $signed(base[item[4:0]]) |-> item_v == 0;
  endproperty
  a_zeroed: assert property (p_zeroed)
    else $error("baseline not subtracted");

  property p_node_range;
    can_node_o >= 8'h01 && can_node_o <= 8'h7F;
  endproperty
  a_node_range: assert property (p_node_range)
    else $error("node id out of range");

  property p_codes;
    link_mode_o <= 2'h2 && baud_code_o <= 3'h4;
  endproperty
  a_codes: assert property (p_codes)
    else $error("link or bitrate code out of range");

  property p_cr_end;
    state == S_END && slot_free |=> tx_valid_o && tx_data_o == 8'h0D;
  endproperty
  a_cr_end: assert property (p_cr_end)
    else $error("reply not ended by carriage return");

  property p_zero_len;
    $rose(state == S_ZERO) |-> item == 6'h0 ##31 item == 6'h1F ##1
      state == S_ACK;
  endproperty
  a_zero_len: assert property (p_zero_len)
    else $error("baseline capture not 32 cycles");

  property p_serial_items;
    state == S_EXEC && get_n != 0 && name == tsq_pkg::CMD_SERIAL |=>
      n_items == 6'h2;
  endproperty
  a_serial_items: assert property (p_serial_items)
    else $error("serial setup reply item count wrong");

  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus ack timing wrong");

  c_zeroed: cover property (state == S_WAIT && fmt_done &&
                            name == tsq_pkg::CMD_ZEROED && item == 6'h1F);
  c_can_set: cover property (state == S_EXEC && set_ok &&
                             name == tsq_pkg::CMD_CAN);
  c_capture: cover property (state == S_ZERO && item == 6'h1F);
endmodule : tsq_cmd_top

/* File: common/tsq_pkg.sv */
// Shared constants of the track sensor command interpreter
package tsq_pkg;
  // Line characters
  localparam logic [7:0] CHR_CR    = 8'h0D;
  localparam logic [7:0] CHR_LF    = 8'h0A;
  localparam logic [7:0] CHR_GET   = 8'h3F;
  localparam logic [7:0] CHR_SET   = 8'h21;
  localparam logic [7:0] CHR_COMMA = 8'h2C;
  localparam logic [7:0] CHR_DIG0  = 8'h30;
  localparam logic [7:0] CHR_DIG9  = 8'h39;
  localparam logic [7:0] CHR_MINUS = 8'h2D;
  localparam logic [7:0] CHR_OK    = 8'h2B;
  localparam logic [3:0] NAME_END  = 4'h5;
  localparam logic [2:0] MAX_ARGS  = 3'h4;
  localparam logic [19:0] ARG_MAX  = 20'h0FFFF;
  // Command names, four ASCII characters packed first-char-high
  localparam logic [31:0] CMD_ZEROED = 32'h5253454E;
  localparam logic [31:0] CMD_UNCORR = 32'h52415753;
  localparam logic [31:0] CMD_STATUS = 32'h53544154;
  localparam logic [31:0] CMD_TAPE   = 32'h54504F4C;
  localparam logic [31:0] CMD_LINK   = 32'h434D4346;
  localparam logic [31:0] CMD_SERIAL = 32'h52534346;
  localparam logic [31:0] CMD_CAN    = 32'h434E4346;
  localparam logic [31:0] CMD_ZERO   = 32'h5A45524F;
  // Reply item counts
  localparam logic [5:0] N_SENSORS = 6'h20;
  localparam logic [5:0] N_ONE     = 6'h01;
  localparam logic [5:0] N_SERIAL  = 6'h02;
  localparam logic [5:0] N_CAN     = 6'h04;
  localparam logic [4:0] SENS_LAST = 5'h1F;
  localparam logic signed [17:0] FIELD_LIMIT = 18'sh03E80;
  // Factory defaults
  localparam logic       DEF_TAPE_POL = 1'h0;
  localparam logic [1:0] DEF_LINK     = 2'h0;
  localparam logic [2:0] DEF_BAUD     = 3'h4;
  localparam logic       DEF_INV      = 1'h0;
  localparam logic [7:0] DEF_NODE     = 8'h01;
  localparam logic [1:0] DEF_CRATE    = 2'h1;
  localparam logic [15:0] DEF_PERIOD  = 16'h0014;
  localparam logic       DEF_TERM     = 1'h0;
  // Argument limits
  localparam logic [15:0] LIM_BIT   = 16'h0001;
  localparam logic [15:0] LIM_LINK  = 16'h0002;
  localparam logic [15:0] LIM_BAUD  = 16'h0004;
  localparam logic [15:0] LIM_NODE  = 16'h007F;
  localparam logic [15:0] LIM_CRATE = 16'h0003;
  // Register bus map
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_CFG  = 4'h8;
  localparam logic       DEF_ENABLE = 1'h1;
  // Decimal weights, most significant first
  localparam logic [4:0][16:0] POW10 = {17'h00001, 17'h0000A, 17'h00064,
                                        17'h003E8, 17'h02710};
endpackage : tsq_pkg

/* File: rtl/tsq_line_parser.sv */
// Splits received command lines into kind, name and numeric arguments
`timescale 1ns/1ps
module tsq_line_parser (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             byte_stb_i,
  input  wire logic [7:0]       byte_i,
  output logic                  line_stb_o,
  output logic                  is_get_o,
  output logic [31:0]           name_o,
  output logic [2:0]            argc_o,
  output logic [3:0][15:0]      args_o,
  output logic                  bad_o
);
  logic [3:0]  pos;
  logic [1:0]  cur_idx;
  logic [19:0] acc;
  logic        is_dig;

  always_comb begin
    cur_idx = 2'(argc_o - 3'h1);
    is_dig  = (byte_i >= tsq_pkg::CHR_DIG0) && (byte_i <= tsq_pkg::CHR_DIG9);
    acc     = {4'h0, args_o[cur_idx]} * 20'h0000A
              + {12'h000, byte_i - tsq_pkg::CHR_DIG0};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos        <= 4'h0;
      line_stb_o <= 1'b0;
      is_get_o   <= 1'b0;
      name_o     <= 32'h0;
      argc_o     <= 3'h0;
      args_o     <= '0;
      bad_o      <= 1'b0;
    end else begin
      line_stb_o <= 1'b0;
      if (byte_stb_i && byte_i != tsq_pkg::CHR_LF) begin
        if (byte_i == tsq_pkg::CHR_CR) begin
          line_stb_o <= (pos != 4'h0);
          if (pos != tsq_pkg::NAME_END) bad_o <= 1'b1;
          pos <= 4'h0;
        end else if (pos == 4'h0) begin
          is_get_o <= (byte_i == tsq_pkg::CHR_GET);
          bad_o    <= !(byte_i == tsq_pkg::CHR_GET ||
                        byte_i == tsq_pkg::CHR_SET);
          name_o   <= 32'h0;
          argc_o   <= 3'h0;
          args_o   <= '0;
          pos      <= 4'h1;
        end else if (pos != tsq_pkg::NAME_END) begin
          name_o <= {name_o[23:0], byte_i};
          pos    <= pos + 4'h1;
        end else if (byte_i == tsq_pkg::CHR_COMMA) begin
          if (argc_o == tsq_pkg::MAX_ARGS) bad_o <= 1'b1;
          else argc_o <= argc_o + 3'h1;
        end else if (is_dig && argc_o != 3'h0) begin
          // Overflow flags the line rather than wrapping silently
          if (acc > tsq_pkg::ARG_MAX) bad_o <= 1'b1;
          else args_o[cur_idx] <= acc[15:0];
        end else begin
          bad_o <= 1'b1;
        end
      end
    end
  end
endmodule : tsq_line_parser

/* File: rtl/tsq_dec_fmt.sv */
// Streams a signed value out as ASCII decimal without leading zeros
`timescale 1ns/1ps
module tsq_dec_fmt (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               start_i,
  input  wire logic signed [17:0] value_i,
  output logic                    out_valid_o,
  output logic [7:0]              out_data_o,
  input  wire logic               out_ready_i,
  output logic                    done_o
);
  typedef enum logic [3:0] {
    F_IDLE = 4'b0001,
    F_SIGN = 4'b0010,
    F_CALC = 4'b0100,
    F_EMIT = 4'b1000
  } tsq_fmt_state_t;

  tsq_fmt_state_t state;
  logic [16:0]    mag;
  logic [2:0]     pw;
  logic [3:0]     digit;
  logic           seen;
  logic           show;

  always_comb begin
    show        = (digit != 4'h0) || seen || (pw == 3'h4);
    out_valid_o = (state == F_SIGN) || (state == F_EMIT && show);
    out_data_o  = (state == F_SIGN) ? tsq_pkg::CHR_MINUS
                                    : tsq_pkg::CHR_DIG0 + {4'h0, digit};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= F_IDLE;
      mag    <= 17'h0;
      pw     <= 3'h0;
      digit  <= 4'h0;
      seen   <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        F_IDLE: if (start_i) begin
          mag   <= value_i[17] ? 17'(-value_i) : value_i[16:0];
          pw    <= 3'h0;
          digit <= 4'h0;
          seen  <= 1'b0;
          state <= value_i[17] ? F_SIGN : F_CALC;
        end
        F_SIGN: if (out_ready_i) state <= F_CALC;
        // One subtraction a cycle keeps the datapath free of dividers
        F_CALC: if (mag >= tsq_pkg::POW10[pw]) begin
          mag   <= mag - tsq_pkg::POW10[pw];
          digit <= digit + 4'h1;
        end else begin
          state <= F_EMIT;
        end
        F_EMIT: if (!show || out_ready_i) begin
          seen  <= show;
          digit <= 4'h0;
          if (pw == 3'h4) begin
            done_o <= 1'b1;
            state  <= F_IDLE;
          end else begin
            pw    <= pw + 3'h1;
            state <= F_CALC;
          end
        end
        default: state <= F_IDLE;
      endcase
    end
  end
endmodule : tsq_dec_fmt

/* File: dv/tsq_host_model.sv */
// Host model: sends command lines, collects reply lines
`timescale 1ns/1ps
module tsq_host_model (
  input  wire logic       clk_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b1;
  end
  task automatic xfer(input string c, output string r);
    string s;
    int k;
    s = {c, "\r"};
    r = "";
    for (int i = 0; i < s.len(); i++) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= s[i];
      for (k = 0; k < 50; k++) begin
        @(posedge clk_i);
        if (rx_ready_i) break;
      end
      // A refused byte spoils the reply so the bench counts it
      if (k == 50) r = "hang";
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~s[s.len()-1];
    // Random stalls on the reply side
    for (k = 0; k < 4000; k++) begin
      @(posedge clk_i);
      if (tx_valid_i && tx_ready_o) begin
        if (tx_data_i == 8'h0D) break;
        r = {r, string'(tx_data_i)};
      end
      tx_ready_o <= ($urandom_range(3) != 0);
    end
    if (k == 4000) r = "hang";
  endtask : xfer
endmodule : tsq_host_model

/* File: dv/tsq_cmd_top_tb.sv */
// Self-checking bench of the command interpreter
`timescale 1ns/1ps
`define CHK(a,b) begin compares++; if ((a)!==(b)) begin err_total++; \
  $display("FAIL %0t mismatch", $time); end end
module tsq_cmd_top_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, rm = 1'b0, lm = 1'b0, flt = 1'b0;
  logic [1:0]  trk = 2'h0, lmode, crate;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rd, dato;
  logic        ack, rxv, rxr, txv, txr, tp, mp, inv, term;
  logic [7:0]  rxd, txd, node;
  logic [2:0]  baud;
  logic [4:0]  idx;
  logic [15:0] per, sv [32];
  int          err_total = 0, compares = 0, lines = 0, e, v, q, t, bs [32];
  string       r, x;
  initial forever #5 clk_i = ~clk_i;
  tsq_cmd_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .rx_valid_i(rxv),
    .rx_data_i(rxd), .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd),
    .tx_ready_i(txr), .sensor_idx_o(idx), .sensor_val_i(sv[idx]),
    .right_marker_i(rm), .left_marker_i(lm), .track_detect_i(trk),
    .sensor_fault_i(flt), .tape_pol_o(tp), .marker_pol_o(mp),
    .link_mode_o(lmode), .baud_code_o(baud), .serial_inv_o(inv),
    .can_node_o(node), .can_rate_o(crate), .can_period_o(per),
    .can_term_o(term));
  tsq_host_model host (.clk_i(clk_i), .rx_valid_o(rxv), .rx_data_o(rxd),
    .rx_ready_i(rxr), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr));
  task automatic wb(input logic w, input logic [3:0] a, input int d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    for (int k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk_i);
    `CHK(ack, 1'b1)
    rd = dato;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task automatic cmd(input string c, input string ex);
    lines++;
    host.xfer(c, r);
    `CHK(r == ex, 1'b1)
  endtask : cmd
  function automatic string nm(input string lead, input logic [31:0] n);
    return $sformatf("%s%s", lead, n);
  endfunction : nm
  // Set command: name, arguments and expected one-character reply
  task automatic put(input logic [31:0] n, input string a, input string ex);
    cmd({nm("!", n), a}, ex);
  endtask : put
  // Query: the reply repeats the name, then the expected values
  task automatic qry(input logic [31:0] n, input string vals);
    cmd(nm("?", n), {nm("?", n), vals});
  endtask : qry
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
  initial begin
    e = $urandom(59100);
    foreach (sv[i]) sv[i] = $urandom;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 4'h8, 0); `CHK(rd, {16'h14, 7'h1, 1'b0, 4'h4, 4'h4})
    wb(0, 4'hC, 0); `CHK(rd, 32'h0)
    wb(1, 4'h0, 0); @(posedge clk_i); `CHK(rxr, 1'b0)
    wb(1, 4'h0, 1);
    repeat (3) begin
      {rm, lm, trk, flt} <= 5'($urandom);
      @(posedge clk_i);
      cmd("?STAT", $sformatf("?STAT,%0d", {flt, trk, lm, rm}));
    end
    cmd("?STAT,1", "-");
    wb(0, 4'h4, 0);
    // Marker 1, tape 0, last line refused, idle
    `CHK(rd, {16'h0, lines[7:0], 8'h0A})
    for (int p = 1; p >= 0; p--) begin
      put(tsq_pkg::CMD_TAPE, $sformatf(",%0d", p), "+");
      `CHK({tp, mp}, {p[0], ~p[0]})
      qry(tsq_pkg::CMD_TAPE, $sformatf(",%0d", p));
    end
    for (int m = 0; m < 4; m++) begin
      put(tsq_pkg::CMD_LINK, $sformatf(",%0d", m), m < 3 ? "+" : "-");
      `CHK(lmode, m < 3 ? m[1:0] : 2'h2)
    end
    qry(tsq_pkg::CMD_LINK, ",2");
    e = $urandom_range(4);
    v = $urandom_range(1);
    put(tsq_pkg::CMD_SERIAL, $sformatf(",%0d,%0d", e, v), "+");
    `CHK({baud, inv}, {e[2:0], v[0]})
    put(tsq_pkg::CMD_SERIAL, ",5,0", "-");
    qry(tsq_pkg::CMD_SERIAL, $sformatf(",%0d,%0d", e, v));
    e = $urandom_range(127, 1);
    v = $urandom_range(65535);
    q = $urandom_range(3);
    t = $urandom_range(1);
    x = $sformatf(",%0d,%0d,%0d,%0d", e, q, v, t);
    put(tsq_pkg::CMD_CAN, x, "+");
    `CHK({node, crate, per, term}, {e[7:0], q[1:0], v[15:0], t[0]})
    put(tsq_pkg::CMD_CAN, ",0,1,20,0", "-");
    qry(tsq_pkg::CMD_CAN, x);
    x = "";
    foreach (sv[i]) begin
      v = $signed(sv[i]);
      v = v > 16000 ? 16000 : (v < -16000 ? -16000 : v);
      x = {x, $sformatf(",%0d", v)};
    end
    qry(tsq_pkg::CMD_UNCORR, x);
    // Small fields keep the difference inside the clamp range
    foreach (bs[i]) begin
      bs[i] = $urandom_range(16000) - 8000;
      sv[i] <= bs[i];
    end
    @(posedge clk_i);
    cmd("!ZERO", "+");
    x = "";
    foreach (sv[i]) begin
      v = $urandom_range(16000) - 8000;
      sv[i] <= v;
      x = {x, $sformatf(",%0d", v - bs[i])};
    end
    qry(tsq_pkg::CMD_ZEROED, x);
    tally_and_finish();
  end
endmodule : tsq_cmd_top_tb
